// >>> core/adc_serial_command_decoder.sv
// Serial command decoder with register file, result readout and modes
// Operation
// - Read-result command shifts out the latest 24-bit conversion result.
// - Continuous-read command outputs each new result whose ready assertion arrives while no result is being sent.
// - Continuous mode ends when a received byte is stop or reset opcode.
// - Stop-continuous command ends continuous result output.
// - Register read: start address, then count; count plus one registers, max 16.
// - Multi-register access wraps address from last register back to zero.
// - Register write: start address, count, then count plus one data bytes.
// - Full self calibration updates offset and full-scale coefficients.
// - Offset self calibration updates only the offset coefficient.
// - Gain self calibration updates the full-scale coefficient.
// - System offset calibration writes offset coefficient from applied zero input.
// - System gain calibration writes full-scale coefficient from applied input.
// - Sleep command enters sleep until the resume command arrives.
// - Resume command returns from sleep to normal operation.
// - Align command restarts conversion and ready timing at command receipt.
// - Soft reset restores all registers and ends continuous mode.
// - Input bytes are MSB first; output order follows the bit-order control.
// - Result low byte is read-only at 0F, resets to 00.
// - Control register bit 3 selects output order, zero means MSB first.
// - Control register bit 7 reads back the ready pin state.
// - Result high and middle bytes are read-only at 0D and 0E.
`timescale 1ns/1ps
module adc_serial_command_decoder
   import cmd_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        SCLK_I,
   input  wire logic        CS_N_I,
   input  wire logic        DIN_I,
   output logic             DOUT_O,
   input  wire logic [23:0] RESULT_I,
   input  wire logic        RESULT_STROBE_I,
   output logic             RESULT_AVAILABLE_N_O,
   output logic             CONT_MODE_O,
   output logic             SLEEP_O,
   output logic             SYNC_O,
   output logic             CAL_BUSY_O
);
   link_if lk ();

   state_e      state_ff;
   logic [3:0]  addr_ff;
   logic [4:0]  count_ff;
   logic [7:0]  regs_ff [NUM_REGS];
   logic        cont_ff;
   logic        sleep_ff;
   logic        result_available_n_n_ff;
   logic        sync_ff;
   logic        tx_tgl_ff;
   logic [7:0]  tx_byte_ff;
   logic [2:0]  rx_sync_ff;
   logic [2:0]  ack_sync_ff;
   logic        rx_seen_ff;

   logic [7:0]  rx_byte;
   logic        rx_new;
   logic        tx_idle;
   logic        first;
   logic        is_read_res;
   logic        is_cont;
   logic        is_stop;
   logic        is_register_read_cmd;
   logic        is_register_write_cmd;
   logic        is_cal;
   logic        is_sleep;
   logic        is_wake;
   logic        is_sync;
   logic        soft_rst;
   logic        res_latch;
   logic        cont_start;
   logic        wr_fire;
   logic        send_fire;
   logic        send_last;
   logic        lsb_first;
   logic [7:0]  rd_val;
   logic [2:0]  cal_kind;
   logic        cal_rst_n;
   logic        cal_upd_ofs;
   logic        cal_upd_fs;
   logic [23:0] cal_coeff;

   spi_shifter u_shifter (
      .sclk_i  (SCLK_I),
      .rst_n_i (RST_N_I),
      .cs_n_i  (CS_N_I),
      .din_i   (DIN_I),
      .dout_o  (DOUT_O),
      .lk      (lk.link)
   );

   assign cal_rst_n = RST_N_I && !soft_rst;

   cal_engine u_cal (
      .clk_i     (CLK_I),
      .rst_n_i   (cal_rst_n),
      .start_i   (is_cal),
      .kind_i    (cal_kind),
      .sample_i  ({regs_ff[13], regs_ff[14], regs_ff[15]}),
      .busy_o    (CAL_BUSY_O),
      .upd_ofs_o (cal_upd_ofs),
      .upd_fs_o  (cal_upd_fs),
      .coeff_o   (cal_coeff)
   );

   assign lk.tx_byte = tx_byte_ff;
   assign lk.tx_tgl  = tx_tgl_ff;

   assign RESULT_AVAILABLE_N_O = result_available_n_n_ff;
   assign CONT_MODE_O          = cont_ff;
   assign SLEEP_O              = sleep_ff;
   assign SYNC_O               = sync_ff;

   // A byte or ack counts once the last two synchroniser stages agree
   assign rx_byte = lk.rx_byte;
   assign rx_new  = (rx_sync_ff[1] == rx_sync_ff[2]) && (rx_sync_ff[2] != rx_seen_ff);
   assign tx_idle = (ack_sync_ff[1] == ack_sync_ff[2]) && (ack_sync_ff[2] == tx_tgl_ff);

   // First-byte slot of a fresh command
   assign first       = rx_new && state_ff == ST_IDLE && !cont_ff && !sleep_ff;
   assign is_read_res = first && rx_byte == OP_READ_RESULT;
   assign is_cont     = first && rx_byte == OP_CONT_RESULT;
   assign is_stop     = rx_new && cont_ff && rx_byte == OP_HALT_CONT;
   assign is_register_read_cmd     = first && rx_byte[7:4] == OP_REG_READ_HI;
   assign is_register_write_cmd     = first && rx_byte[7:4] == OP_REG_WRITE_HI;
   assign is_sleep    = first && rx_byte == OP_SLEEP;
   assign is_sync     = first && rx_byte == OP_ALIGN_CONV;
   assign is_wake     = rx_new && sleep_ff && state_ff == ST_IDLE && rx_byte == OP_RESUME;
   // In continuous mode reset is honoured even while a result streams out
   assign soft_rst    = rx_new && !sleep_ff && rx_byte == OP_SOFT_RESET
                        && (cont_ff || state_ff == ST_IDLE);

   assign res_latch  = RESULT_STROBE_I && !sleep_ff && !CAL_BUSY_O;
   assign cont_start = cont_ff && res_latch && state_ff == ST_IDLE && !soft_rst;
   assign wr_fire    = rx_new && state_ff == ST_WR_DATA;
   assign send_fire  = state_ff == ST_SEND && tx_idle;
   assign send_last  = send_fire && count_ff == 5'h01;
   assign lsb_first  = regs_ff[ADDR_ACR][ACR_BIT_ORDER_POS];

   always_comb begin
      cal_kind = 3'h0;
      is_cal   = first;
      case (rx_byte)
         OP_INT_FULL_CAL : cal_kind = 3'h3;
         OP_INT_OFS_CAL  : cal_kind = 3'h1;
         OP_INT_GAIN_CAL : cal_kind = 3'h2;
         OP_EXT_OFS_CAL  : cal_kind = 3'h5;
         OP_EXT_GAIN_CAL : cal_kind = 3'h6;
         default         : is_cal   = 1'b0;
      endcase
   end

   always_comb begin
      rd_val = regs_ff[addr_ff];
      if (addr_ff == ADDR_ACR) begin
         rd_val[ACR_READY_POS] = result_available_n_n_ff;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rx_sync_ff  <= 3'h0;
         ack_sync_ff <= 3'h0;
         rx_seen_ff  <= 1'b0;
      end else begin
         rx_sync_ff  <= {rx_sync_ff[1:0], lk.rx_tgl};
         ack_sync_ff <= {ack_sync_ff[1:0], lk.tx_ack_tgl};
         if (rx_new) begin
            rx_seen_ff <= rx_sync_ff[2];
         end
      end
   end

   // Command sequencing; any byte outside a known opcode leaves everything alone
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I || soft_rst) begin
         state_ff <= ST_IDLE;
         addr_ff  <= 4'h0;
         count_ff <= 5'h00;
      end else begin
         case (state_ff)
            ST_IDLE : begin
               if (is_read_res || cont_start) begin
                  state_ff <= ST_SEND;
                  addr_ff  <= ADDR_RES_MSB;
                  count_ff <= RESULT_BYTES;
               end else if (is_register_read_cmd) begin
                  state_ff <= ST_RD_COUNT;
                  addr_ff  <= rx_byte[3:0];
               end else if (is_register_write_cmd) begin
                  state_ff <= ST_WR_COUNT;
                  addr_ff  <= rx_byte[3:0];
               end
            end
            ST_RD_COUNT : begin
               if (rx_new) begin
                  count_ff <= {1'b0, rx_byte[3:0]} + 5'h01;
                  state_ff <= ST_SEND;
               end
            end
            ST_WR_COUNT : begin
               if (rx_new) begin
                  count_ff <= {1'b0, rx_byte[3:0]} + 5'h01;
                  state_ff <= ST_WR_DATA;
               end
            end
            ST_WR_DATA : begin
               if (rx_new) begin
                  addr_ff  <= addr_ff + 4'h1;
                  count_ff <= count_ff - 5'h01;
                  if (count_ff == 5'h01) begin
                     state_ff <= ST_IDLE;
                  end
               end
            end
            ST_SEND : begin
               if (send_fire) begin
                  addr_ff  <= addr_ff + 4'h1;
                  count_ff <= count_ff - 5'h01;
                  if (send_last) begin
                     state_ff <= ST_IDLE;
                  end
               end
            end
            default : state_ff <= ST_IDLE;
         endcase
      end
   end

   // Toggle is never touched by soft reset so the crossing stays in step
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         tx_byte_ff <= 8'h00;
         tx_tgl_ff  <= 1'b0;
      end else if (send_fire) begin
         tx_byte_ff <= lsb_first ? bit_reverse(rd_val) : rd_val;
         tx_tgl_ff  <= ~tx_tgl_ff;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I || soft_rst || is_stop) begin
         cont_ff <= 1'b0;
      end else if (is_cont) begin
         cont_ff <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I || is_wake) begin
         sleep_ff <= 1'b0;
      end else if (is_sleep) begin
         sleep_ff <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         sync_ff <= 1'b0;
      end else begin
         sync_ff <= is_sync;
      end
   end

   // A new result wins over a clear in the same cycle
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         result_available_n_n_ff <= 1'b1;
      end else if (res_latch) begin
         result_available_n_n_ff <= 1'b0;
      end else if (soft_rst || is_sync || (send_last && addr_ff == ADDR_RES_LSB)) begin
         result_available_n_n_ff <= 1'b1;
      end
   end

   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      if (g >= ADDR_RES_MSB_I) begin : g_res
         // Result bytes ignore host writes
         always_ff @(posedge CLK_I) begin
            if (!RST_N_I || soft_rst) begin
               regs_ff[g] <= REG_RESET[g];
            end else if (res_latch) begin
               regs_ff[g] <= RESULT_I[8*(NUM_REGS-1-g) +: 8];
            end
         end
      end else begin : g_rw
         always_ff @(posedge CLK_I) begin
            if (!RST_N_I || soft_rst) begin
               regs_ff[g] <= REG_RESET[g];
            end else if (g >= ADDR_OCR0 && g < ADDR_FSR0 && cal_upd_ofs) begin
               regs_ff[g] <= cal_coeff[8*((g-ADDR_OCR0)%3) +: 8];
            end else if (g >= ADDR_FSR0 && cal_upd_fs) begin
               regs_ff[g] <= cal_coeff[8*((g-ADDR_FSR0)%3) +: 8];
            end else if (wr_fire && addr_ff == 4'(g)) begin
               regs_ff[g] <= rx_byte;
            end
         end
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   read_result_a :
      assert property (is_read_res |=> state_ff == ST_SEND && addr_ff == ADDR_RES_MSB
                       && count_ff == RESULT_BYTES)
      else $error("Read result did not start a three byte send");
   cont_launch_a :
      assert property (cont_start |=> state_ff == ST_SEND && addr_ff == ADDR_RES_MSB)
      else $error("Continuous mode missed a new result");
   cont_exit_a :
      assert property (rx_new && cont_ff && (rx_byte == OP_HALT_CONT
                       || rx_byte == OP_SOFT_RESET) |=> !cont_ff)
      else $error("Continuous mode not left on stop or reset");
   halt_cont_a :
      assert property (is_stop |=> !cont_ff ##1 !cont_ff)
      else $error("Stop command did not end continuous mode");
   read_count_a :
      assert property (state_ff == ST_RD_COUNT && rx_new |=>
                       state_ff == ST_SEND && count_ff == {1'b0, $past(rx_byte[3:0])} + 5'h01)
      else $error("Register read count wrong");
   addr_wrap_a :
      assert property (send_fire && addr_ff == 4'hF && !send_last |=> addr_ff == 4'h0)
      else $error("Address did not wrap to zero");
   write_store_a :
      assert property (wr_fire && addr_ff < ADDR_RES_MSB && !CAL_BUSY_O && !cal_upd_ofs
                       && !cal_upd_fs |=> regs_ff[$past(addr_ff)] == $past(rx_byte))
      else $error("Register write not stored");
   sleep_hold_a :
      assert property (sleep_ff && !is_wake |=> sleep_ff)
      else $error("Sleep left without resume");
   resume_a :
      assert property (is_wake |=> !sleep_ff)
      else $error("Resume did not leave sleep");
   align_a :
      assert property (is_sync && !res_latch |=> SYNC_O && RESULT_AVAILABLE_N_O ##1 !SYNC_O)
      else $error("Align command did not restart timing");
   soft_reset_a :
      assert property (soft_rst |=> !cont_ff && regs_ff[ADDR_FSR0] == REG_RESET[ADDR_FSR0]
                       && state_ff == ST_IDLE)
      else $error("Soft reset did not restore state");
   bit_order_a :
      assert property (send_fire && lsb_first |=> tx_byte_ff == bit_reverse($past(rd_val)))
      else $error("Output bit order not applied");
   ready_mirror_a :
      assert property (addr_ff == ADDR_ACR |-> rd_val[ACR_READY_POS] == RESULT_AVAILABLE_N_O)
      else $error("Ready flag does not mirror pin");
   result_low_a :
      assert property (res_latch && !soft_rst |=> regs_ff[15] == $past(RESULT_I[7:0])
                       && !RESULT_AVAILABLE_N_O)
      else $error("Result low byte not captured");
   unknown_op_a :
      assert property (first && !is_read_res && !is_cont && !is_register_read_cmd && !is_register_write_cmd && !is_cal
                       && !is_sleep && !is_sync && !soft_rst |=> state_ff == ST_IDLE
                       && $stable(cont_ff) && $stable(sleep_ff))
      else $error("Unknown opcode changed state");

   cont_read_c  : cover property (cont_start ##[1:400] send_last);
   wrap_read_c  : cover property (send_fire && addr_ff == 4'hF && !send_last);
   write_c      : cover property (wr_fire ##[1:400] state_ff == ST_IDLE);
   cal_done_c   : cover property (cal_upd_ofs && cal_upd_fs);
   sleep_wake_c : cover property (is_sleep ##[1:400] is_wake);
endmodule : adc_serial_command_decoder

// >>> core/cmd_pkg.sv
// Opcodes, register map, reset values and timing counts of the command decoder
package cmd_pkg;
   localparam logic [7:0] OP_READ_RESULT    = 8'h01;
   localparam logic [7:0] OP_CONT_RESULT    = 8'h03;
   localparam logic [7:0] OP_HALT_CONT      = 8'h0F;
   localparam logic [3:0] OP_REG_READ_HI    = 4'h1;
   localparam logic [3:0] OP_REG_WRITE_HI   = 4'h5;
   localparam logic [7:0] OP_INT_FULL_CAL   = 8'hF0;
   localparam logic [7:0] OP_INT_OFS_CAL    = 8'hF1;
   localparam logic [7:0] OP_INT_GAIN_CAL   = 8'hF2;
   localparam logic [7:0] OP_EXT_OFS_CAL    = 8'hF3;
   localparam logic [7:0] OP_EXT_GAIN_CAL   = 8'hF4;
   localparam logic [7:0] OP_RESUME         = 8'hFB;
   localparam logic [7:0] OP_ALIGN_CONV     = 8'hFC;
   localparam logic [7:0] OP_SLEEP          = 8'hFD;
   localparam logic [7:0] OP_SOFT_RESET     = 8'hFE;

   localparam int         NUM_REGS          = 16;
   localparam logic [3:0] ADDR_ACR          = 4'h2;
   localparam int         ADDR_OCR0         = 7;
   localparam int         ADDR_FSR0         = 10;
   localparam int         ADDR_RES_MSB_I    = 13;
   localparam logic [3:0] ADDR_RES_MSB      = 4'hD;
   localparam logic [3:0] ADDR_RES_LSB      = 4'hF;
   localparam int         ACR_BIT_ORDER_POS = 3;
   localparam int         ACR_READY_POS     = 7;
   localparam logic [4:0] RESULT_BYTES      = 5'h03;

   // Arbitrary identity nibble, not a real part code
   localparam logic [3:0] DEVICE_ID         = 4'h0;
   localparam logic [7:0] REG_RESET [NUM_REGS] = '{
      {DEVICE_ID, 4'h0}, 8'h01, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h59, 8'h55, 8'h55, 8'h00, 8'h00, 8'h00};

   // Calibration kind bits and cycle count
   localparam int         CAL_KIND_OFS      = 0;
   localparam int         CAL_KIND_FS       = 1;
   localparam int         CAL_KIND_SYS      = 2;
   localparam logic [7:0] CAL_CYCLES        = 8'h40;

   typedef enum logic [4:0] {
      ST_IDLE     = 5'h01,
      ST_RD_COUNT = 5'h02,
      ST_WR_COUNT = 5'h04,
      ST_WR_DATA  = 5'h08,
      ST_SEND     = 5'h10
   } state_e;

   function automatic logic [7:0] bit_reverse(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction : bit_reverse
endpackage : cmd_pkg

// >>> core/link_if.sv
// Byte handshake between the serial-clock side and the core side
`timescale 1ns/1ps
interface link_if;
   logic [7:0] rx_byte;
   logic       rx_tgl;
   logic [7:0] tx_byte;
   logic       tx_tgl;
   logic       tx_ack_tgl;
   modport link (output rx_byte, rx_tgl, tx_ack_tgl, input tx_byte, tx_tgl);
   modport core (input rx_byte, rx_tgl, tx_ack_tgl, output tx_byte, tx_tgl);
endinterface : link_if

// >>> core/spi_shifter.sv
// Serial shifter running on the host's serial clock
`timescale 1ns/1ps
module spi_shifter (
   input  wire logic sclk_i,
   input  wire logic rst_n_i,
   input  wire logic cs_n_i,
   input  wire logic din_i,
   output logic      dout_o,
   link_if.link      lk
);
   logic [2:0] bit_cnt_ff;
   logic [6:0] rx_sh_ff;
   logic [7:0] tx_sh_ff;
   logic [7:0] rx_byte_ff;
   logic       rx_tgl_ff;
   logic       ack_ff;
   logic [2:0] req_sync_ff;
   logic       req_pending;

   // Request counts only once the last two stages agree
   assign req_pending = (req_sync_ff[1] == req_sync_ff[2]) && (req_sync_ff[2] != ack_ff);
   assign dout_o      = tx_sh_ff[7];
   assign lk.rx_byte  = rx_byte_ff;
   assign lk.rx_tgl   = rx_tgl_ff;
   assign lk.tx_ack_tgl = ack_ff;

   // Frame position restarts whenever chip select is released
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bit_cnt_ff <= 3'h0;
         rx_sh_ff   <= 7'h00;
         tx_sh_ff   <= 8'h00;
      end else begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         rx_sh_ff   <= {rx_sh_ff[5:0], din_i};
         if (bit_cnt_ff == 3'h0) begin
            tx_sh_ff <= req_pending ? lk.tx_byte : 8'h00;
         end else begin
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
         end
      end
   end

   // Handshake state survives chip select so toggles never glitch
   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_byte_ff  <= 8'h00;
         rx_tgl_ff   <= 1'b0;
         ack_ff      <= 1'b0;
         req_sync_ff <= 3'h0;
      end else begin
         req_sync_ff <= {req_sync_ff[1:0], lk.tx_tgl};
         if (!cs_n_i && bit_cnt_ff == 3'h7) begin
            rx_byte_ff <= {rx_sh_ff, din_i};
            rx_tgl_ff  <= ~rx_tgl_ff;
         end
         if (!cs_n_i && bit_cnt_ff == 3'h0 && req_pending) begin
            ack_ff <= req_sync_ff[2];
         end
      end
   end
endmodule : spi_shifter

// >>> core/cal_engine.sv
// Calibration sequencer that captures new coefficients
`timescale 1ns/1ps
module cal_engine
   import cmd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire logic [2:0]  kind_i,
   input  wire logic [23:0] sample_i,
   output logic             busy_o,
   output logic             upd_ofs_o,
   output logic             upd_fs_o,
   output logic [23:0]      coeff_o
);
   logic [7:0] cnt_ff;
   logic [2:0] kind_ff;
   logic       finish;

   assign finish = busy_o && (cnt_ff == 8'h01);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         busy_o  <= 1'b0;
         cnt_ff  <= 8'h00;
         kind_ff <= 3'h0;
      end else if (start_i && !busy_o) begin
         busy_o  <= 1'b1;
         cnt_ff  <= CAL_CYCLES;
         kind_ff <= kind_i;
      end else if (busy_o) begin
         cnt_ff <= cnt_ff - 8'h01;
         if (finish) begin
            busy_o <= 1'b0;
         end
      end
   end

   // Coefficient arithmetic is outside this block; the applied level is captured
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         upd_ofs_o <= 1'b0;
         upd_fs_o  <= 1'b0;
         coeff_o   <= 24'h00_0000;
      end else begin
         upd_ofs_o <= finish && kind_ff[CAL_KIND_OFS];
         upd_fs_o  <= finish && kind_ff[CAL_KIND_FS];
         if (finish) begin
            coeff_o <= sample_i;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   cal_hold_a :
      assert property ($rose(busy_o) |-> busy_o [*8])
      else $error("Calibration ended too early");
   cal_update_a :
      assert property ($fell(busy_o) && $past(rst_n_i) |->
                       (upd_ofs_o || upd_fs_o) && coeff_o == $past(sample_i))
      else $error("Calibration finished without coefficient update");
endmodule : cal_engine

// >>> test/host_model.sv
// Serial host model; clock stays low outside frames
`timescale 1ns/1ps
module host_model (
   output logic       sclk_o,
   output logic       cs_n_o,
   output logic       din_o,
   input  wire logic  dout_i,
   output logic [7:0] got_o,
   output logic       got_tgl_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o = 1'b0;
      got_tgl_o = 1'b0;
   end
   task automatic xfer(input logic [7:0] tx, input logic chk);
      cs_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         din_o = tx[i];
         #15 sclk_o = 1'b1;
         #15 sclk_o = 1'b0;
         got_o[i] = dout_i;
      end
      #10 cs_n_o = 1'b1;
      din_o = ~din_o;
      // Idle gap lets the received byte cross to the core
      #120 if (chk) got_tgl_o = ~got_tgl_o;
   endtask : xfer
endmodule : host_model

// >>> test/tb_top.sv
// Self-checking bench for the serial command decoder
`timescale 1ns/1ps
module tb_top;
   import cmd_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n;
   logic        stb = 1'b0;
   logic [23:0] res = 24'h00_0000;
   logic        sclk, cs_n, din, dout, result_available_n_n, cont, slp, sync, cal, tgl;
   logic [7:0]  got;
   logic [7:0]  mir [NUM_REGS];
   logic [7:0]  exp_q [$];
   logic        rdy = 1'b1;
   int          failures = 0;
   int          cmp_count = 0;
   int          seed = 36975;
   int          syncs = 0;
   int          n;
   always #2 clk = ~clk;
   always @(posedge clk) if (sync === 1'b1) syncs <= syncs + 1;
   adc_serial_command_decoder i_adc_serial_command_decoder (.CLK_I(clk), .RST_N_I(rst_n),
      .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din), .DOUT_O(dout), .RESULT_I(res),
      .RESULT_STROBE_I(stb), .RESULT_AVAILABLE_N_O(result_available_n_n), .CONT_MODE_O(cont),
      .SLEEP_O(slp), .SYNC_O(sync), .CAL_BUSY_O(cal));
   host_model i_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout),
      .got_o(got), .got_tgl_o(tgl));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic finish_test();
      $display("failures %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   always @(tgl) if ($time > 0) chk("dout", exp_q.pop_front(), got);
   task automatic send(input logic [7:0] b);
      i_host_model.xfer(b, 1'b0);
   endtask : send
   task automatic rd(input logic [7:0] v);
      logic [7:0] r;
      r = {<<{v}};
      exp_q.push_back(mir[2][3] ? r : v);
      i_host_model.xfer(8'h00, 1'b1);
   endtask : rd
   task automatic rd_regs(input logic [3:0] a, input logic [3:0] c);
      logic [3:0] p;
      send({OP_REG_READ_HI, a});
      send({4'($random(seed)), c});
      // Answer request crosses on serial clock edges, so one idle frame first
      send(8'h00);
      for (int i = 0; i <= c; i++) begin
         p = a + 4'(i);
         rd(p == ADDR_ACR ? {rdy, mir[2][6:0]} : mir[p]);
         if (p == ADDR_RES_LSB) rdy = 1'b1;
      end
   endtask : rd_regs
   task automatic wr_regs(input logic [3:0] a, input logic [3:0] c);
      logic [3:0] p;
      logic [7:0] d;
      send({OP_REG_WRITE_HI, a});
      send({4'h0, c});
      for (int i = 0; i <= c; i++) begin
         p = a + 4'(i);
         d = 8'($random(seed));
         send(d);
         if (p < ADDR_RES_MSB) mir[p] = d;
      end
   endtask : wr_regs
   task automatic new_result();
      @(posedge clk);
      res <= 24'($random(seed));
      stb <= 1'b1;
      @(posedge clk);
      stb <= 1'b0;
      {mir[13], mir[14], mir[15]} = res;
      rdy = 1'b0;
      repeat (2) @(posedge clk);
      chk("result_available_n_n", 8'h00, 8'(result_available_n_n));
   endtask : new_result
   initial begin
      #200_000;
      failures++;
      finish_test();
   end
   initial begin
      // Falling edge at time zero also clears the serial-side toggles
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      mir = REG_RESET;
      repeat (2) @(posedge clk);
      rd_regs(4'h5, 4'hF);
      wr_regs(4'h2, 4'h3);
      wr_regs(4'hC, 4'h3);
      rd_regs(4'h1, 4'hF);
      send(8'h52);
      send(8'h00);
      send(8'h08);
      mir[2] = 8'h08;
      new_result();
      rd_regs(4'h2, 4'h0);
      send(OP_READ_RESULT);
      send(8'h00);
      for (int i = 13; i < 16; i++) rd(mir[i]);
      rdy = 1'b1;
      rd_regs(4'h2, 4'h0);
      for (int k = 0; k < 5; k++) begin
         new_result();
         send(OP_INT_FULL_CAL + 8'(k));
         chk("cal_busy", 8'h01, 8'(cal));
         n = 0;
         while (cal !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
         end
         if (n == 200) begin
            failures++;
            finish_test();
         end
         if (k != 2 && k != 4) {mir[9], mir[8], mir[7]} = res;
         if (k != 1 && k != 3) {mir[12], mir[11], mir[10]} = res;
         rd_regs(4'h7, 4'h8);
      end
      new_result();
      send(OP_ALIGN_CONV);
      rdy = 1'b1;
      chk("sync", 8'h01, 8'(syncs));
      chk("result_available_n_n", 8'h01, 8'(result_available_n_n));
      send(OP_CONT_RESULT);
      chk("cont", 8'h01, 8'(cont));
      new_result();
      #40;
      send(8'h00);
      for (int i = 13; i < 16; i++) rd(mir[i]);
      rdy = 1'b1;
      send(OP_SLEEP);
      chk("sleep", 8'h00, 8'(slp));
      send(OP_HALT_CONT);
      chk("cont", 8'h00, 8'(cont));
      send(OP_SLEEP);
      send(OP_SOFT_RESET);
      chk("sleep", 8'h01, 8'(slp));
      send(OP_RESUME);
      chk("sleep", 8'h00, 8'(slp));
      send(OP_CONT_RESULT);
      send(OP_SOFT_RESET);
      chk("cont", 8'h00, 8'(cont));
      mir = REG_RESET;
      send(8'h77);
      rd_regs(4'h0, 4'hF);
      @(posedge clk);
      chk("pending", 8'h00, 8'(exp_q.size()));
      finish_test();
   end
endmodule : tb_top
